// [rtl/etc_core.sv]
// module: eight-bit timer with two compare channels, bits as plain ports
//
// Function
// - counter and compare values are 8-bit
// - flags visible, each masked by own bit
// - clock select zero stops all ticks
// - tick from io clock or oscillator pin
// - 0x00 is floor, 0xFF is limit
// - ceiling is limit or compare A
// - each tick clears or steps by one
// - counter readable and writable any time
// - software counter write beats counting
// - three-bit mode field from two registers
// - overflow flag set per mode
// - match sets flag on next tick
// - flags clear on service or write-one
// - waveform output from match and action
// - compare double buffered only in PWM
// - writes hit buffer or active register
// - force strobe acts like match outside PWM, no flag
// - counter write blocks next tick's match
// - output state survives mode change
// - output action field not buffered
// - action zero leaves output unchanged
// - nonzero action overrides port value
`timescale 1ns/1ps
module etc_core (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [2:0] clock_select_field,
	input wire logic async_clock_select,
	input wire logic osc_pin_one,
	input wire logic [1:0] waveform_mode_bits_a,
	input wire logic waveform_mode_bit2,
	input wire logic countWrite,
	input wire logic [7:0] countWrData,
	input wire etc_pkg::etc_chan_s chanA,
	input wire etc_pkg::etc_chan_s chanB,
	input wire logic [2:0] flagWriteOne,
	input wire logic [2:0] irqServiced,
	input wire logic [2:0] irqMaskWrite,
	input wire logic [2:0] irqMaskData,
	input wire logic [1:0] portValue,
	input wire logic [1:0] portDirOut,
	output logic [7:0] count_value,
	output logic [7:0] compare_value_a,
	output logic [7:0] compare_value_b,
	output logic [7:0] compareBufA,
	output logic [7:0] compareBufB,
	output logic [2:0] timer_flag_reg,
	output logic [2:0] timer_irq_mask_reg,
	output logic [2:0] irqRequest,
	output logic compare_out_a,
	output logic compare_out_b,
	output logic [1:0] pinOut,
	output logic [1:0] pinOutEn
);
	////////////////////////////////////////////////////////////////////////
	// tick generation
	logic oscSync1_r, oscSync2_r, oscPrev_r;
	logic oscSync1_nxt, oscSync2_nxt, oscPrev_nxt;
	logic tick;
	// oscillator pin is foreign, two flops before the edge detector
	always_comb begin
		oscSync1_nxt = osc_pin_one;
		oscSync2_nxt = oscSync1_r;
		oscPrev_nxt = oscSync2_r;
	end
	always_ff @(posedge clock) begin
		if (!nrst) begin
			oscSync1_r <= 1'b0;
			oscSync2_r <= 1'b0;
			oscPrev_r <= 1'b0;
		end else begin
			oscSync1_r <= oscSync1_nxt;
			oscSync2_r <= oscSync2_nxt;
			oscPrev_r <= oscPrev_nxt;
		end
	end
	// prescaler left out: any nonzero select ticks at the source rate
	always_comb begin
		if (clock_select_field == etc_pkg::CS_OFF) begin
			tick = 1'b0;
		end else if (async_clock_select) begin
			tick = oscSync2_r & ~oscPrev_r;
		end else begin
			tick = 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// mode decode
	logic [2:0] mode;
	logic isPwm, isPhase, ceilIsA;
	logic [7:0] ceiling;
	always_comb begin
		mode = {waveform_mode_bit2, waveform_mode_bits_a};
		isPhase = (mode == etc_pkg::WGM_PC_FF)
			|| (mode == etc_pkg::WGM_PC_OCA);
		isPwm = isPhase || (mode == etc_pkg::WGM_FAST_FF)
			|| (mode == etc_pkg::WGM_FAST_OCA);
		ceilIsA = (mode == etc_pkg::WGM_CTC) || (mode == etc_pkg::WGM_PC_OCA)
			|| (mode == etc_pkg::WGM_FAST_OCA);
		ceiling = ceilIsA ? compare_value_a : etc_pkg::CNT_LIMIT;
	end
	////////////////////////////////////////////////////////////////////////
	// counter unit
	logic [7:0] count_nxt;
	etc_pkg::etc_dir_e dir_r, dir_nxt;
	logic block_r, block_nxt;
	logic atCeil, atFloor, overflowEv;
	always_comb begin
		atCeil = (count_value == ceiling);
		atFloor = (count_value == etc_pkg::CNT_FLOOR);
		count_nxt = count_value;
		dir_nxt = dir_r;
		overflowEv = 1'b0;
		if (tick) begin
			if (isPhase) begin
				if (dir_r == etc_pkg::DIR_UP && atCeil) begin
					dir_nxt = etc_pkg::DIR_DOWN;
					count_nxt = count_value - 8'h01;
				end else if (dir_r == etc_pkg::DIR_DOWN && atFloor) begin
					dir_nxt = etc_pkg::DIR_UP;
					count_nxt = count_value + 8'h01;
				end else if (dir_r == etc_pkg::DIR_UP) begin
					count_nxt = count_value + 8'h01;
				end else begin
					count_nxt = count_value - 8'h01;
				end
				overflowEv = atFloor;
			end else begin
				dir_nxt = etc_pkg::DIR_UP;
				if (ceilIsA && atCeil) begin
					count_nxt = etc_pkg::CNT_FLOOR;
				end else begin
					count_nxt = count_value + 8'h01;
				end
				// overflow: limit wrap or pwm ceiling
				overflowEv = isPwm ? atCeil
					: (count_value == etc_pkg::CNT_LIMIT);
			end
		end
		if (countWrite) begin
			count_nxt = countWrData;
		end
		// hold the block until the next tick consumes it
		if (countWrite) begin
			block_nxt = 1'b1;
		end else if (tick) begin
			block_nxt = 1'b0;
		end else begin
			block_nxt = block_r;
		end
	end
	always_ff @(posedge clock) begin
		if (!nrst) begin
			count_value <= etc_pkg::RST_BYTE;
			dir_r <= etc_pkg::DIR_UP;
			block_r <= 1'b0;
		end else begin
			count_value <= count_nxt;
			dir_r <= dir_nxt;
			block_r <= block_nxt;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// compare channels
	etc_pkg::etc_chan_s chan [etc_pkg::NCH];
	logic [7:0] act [etc_pkg::NCH];
	logic [7:0] buff [etc_pkg::NCH];
	logic ocState [etc_pkg::NCH];
	logic [etc_pkg::NCH-1:0] matchEv;
	logic updPoint;
	assign chan[0] = chanA;
	assign chan[1] = chanB;
	// pwm update point: ceiling for fast pwm, ceiling for phase too
	assign updPoint = tick && atCeil
		&& (isPhase ? dir_r == etc_pkg::DIR_UP : 1'b1);
	genvar g;
	generate
		for (g = 0; g < etc_pkg::NCH; g++) begin : gCh
			logic [7:0] act_r, act_nxt, buf_r, buf_nxt;
			logic oc_r, oc_nxt, eq, fire;
			always_comb begin
				act_nxt = act_r;
				buf_nxt = buf_r;
				if (chan[g].wrStrobe) begin
					if (isPwm) begin
						buf_nxt = chan[g].wrData;
					end else begin
						act_nxt = chan[g].wrData;
					end
				end
				if (isPwm && updPoint) begin
					act_nxt = chan[g].wrStrobe ? chan[g].wrData : buf_r;
				end
				eq = (count_value == act_r);
				fire = tick && eq && !block_r;
				// state held unless an action occurs
				oc_nxt = oc_r;
				if (!isPwm) begin
					if (fire || chan[g].forceStrobe) begin
						case (chan[g].outputAction)
							2'h1: oc_nxt = ~oc_r;
							2'h2: oc_nxt = 1'b0;
							2'h3: oc_nxt = 1'b1;
							default: oc_nxt = oc_r;
						endcase
					end
				end else if (chan[g].outputAction[1]) begin
					if (fire) begin
						oc_nxt = ~chan[g].outputAction[0]
							^ (isPhase && dir_r == etc_pkg::DIR_DOWN);
					end else if (!isPhase && tick && atFloor) begin
						oc_nxt = chan[g].outputAction[0];
					end
				end else if (chan[g].outputAction[0] && g == 0 && fire
					&& mode == etc_pkg::WGM_FAST_OCA) begin
					oc_nxt = ~oc_r;
				end
			end
			// reset clears compare and output state
			always_ff @(posedge clock) begin
				if (!nrst) begin
					act_r <= etc_pkg::RST_BYTE;
					buf_r <= etc_pkg::RST_BYTE;
					oc_r <= 1'b0;
				end else begin
					act_r <= act_nxt;
					buf_r <= buf_nxt;
					oc_r <= oc_nxt;
				end
			end
			assign act[g] = act_r;
			assign buff[g] = buf_r;
			assign ocState[g] = oc_r;
			assign matchEv[g] = fire;
			assign pinOut[g] = (chan[g].outputAction != 2'h0) ? oc_r : portValue[g];
			assign pinOutEn[g] = portDirOut[g];
		end
	endgenerate
	assign compare_value_a = act[0];
	assign compare_value_b = act[1];
	assign compareBufA = buff[0];
	assign compareBufB = buff[1];
	assign compare_out_a = ocState[0];
	assign compare_out_b = ocState[1];
	////////////////////////////////////////////////////////////////////////
	// flags and masks
	logic [2:0] flag_nxt, mask_nxt, setEv;
	always_comb begin
		setEv = {matchEv[1], matchEv[0], overflowEv};
		// clear by service or write-one, set wins
		flag_nxt = (timer_flag_reg & ~(flagWriteOne | irqServiced)) | setEv;
		mask_nxt = timer_irq_mask_reg;
		for (int i = 0; i < etc_pkg::NFLAG; i++) begin
			if (irqMaskWrite[i]) begin
				mask_nxt[i] = irqMaskData[i];
			end
		end
	end
	always_ff @(posedge clock) begin
		if (!nrst) begin
			timer_flag_reg <= 3'h0;
			timer_irq_mask_reg <= 3'h0;
		end else begin
			timer_flag_reg <= flag_nxt;
			timer_irq_mask_reg <= mask_nxt;
		end
	end
	assign irqRequest = timer_flag_reg & timer_irq_mask_reg;
endmodule

// [rtl/etc_pkg.sv]
// package: constants and types for the eight-bit timer compare core
package etc_pkg;
	localparam logic [7:0] CNT_FLOOR = 8'h00;
	localparam logic [7:0] CNT_LIMIT = 8'hFF;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] CS_OFF = 3'h0;
	// waveform mode encodings
	localparam logic [2:0] WGM_NORMAL = 3'h0;
	localparam logic [2:0] WGM_PC_FF = 3'h1;
	localparam logic [2:0] WGM_CTC = 3'h2;
	localparam logic [2:0] WGM_FAST_FF = 3'h3;
	localparam logic [2:0] WGM_PC_OCA = 3'h5;
	localparam logic [2:0] WGM_FAST_OCA = 3'h7;
	// flag and mask bit positions
	localparam int FLAG_OVF = 0;
	localparam int FLAG_MA = 1;
	localparam int FLAG_MB = 2;
	localparam int NFLAG = 3;
	localparam int NCH = 2;
	// count direction states
	typedef enum logic [1:0] {
		DIR_UP = 2'b01,
		DIR_DOWN = 2'b10
	} etc_dir_e;
	// one compare channel's software settings
	typedef struct packed {
		logic [1:0] outputAction;
		logic forceStrobe;
		logic wrStrobe;
		logic [7:0] wrData;
	} etc_chan_s;
endpackage

// [testbench/etc_core_asserts.sv]
// checker: port-level properties of the timer compare core
`timescale 1ns/1ps
module etc_core_asserts (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [2:0] clock_select_field,
	input wire logic async_clock_select,
	input wire logic [1:0] waveform_mode_bits_a,
	input wire logic waveform_mode_bit2,
	input wire logic countWrite,
	input wire logic [7:0] countWrData,
	input wire logic [2:0] flagWriteOne,
	input wire logic [7:0] count_value,
	input wire logic [2:0] timer_flag_reg,
	input wire logic [2:0] timer_irq_mask_reg,
	input wire logic [2:0] irqRequest
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// normal-mode tick with no software write racing it
	wire logic runUp = clock_select_field != 3'h0 && !async_clock_select
		&& {waveform_mode_bit2, waveform_mode_bits_a} == 3'h0 && !countWrite;
	wire logic stopped = clock_select_field == 3'h0;
////////////////////////////////////////////////////////////////////////////
	property p_rst; $rose(nrst) |-> count_value == 8'h00
		&& timer_flag_reg == 3'h0 && timer_irq_mask_reg == 3'h0; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_wr; countWrite |=> count_value == $past(countWrData);
	endproperty
	a_wr: assert property (p_wr) else $error("count write");
	property p_stop; stopped && !countWrite |=> $stable(count_value);
	endproperty
	a_stop: assert property (p_stop) else $error("stopped count");
	property p_step; runUp |=> count_value == $past(count_value) + 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("count step");
	property p_ovf; runUp && count_value == 8'hFF |=> timer_flag_reg[0];
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow set");
	// overflow must not appear away from the wrap
	property p_novf; runUp && count_value != 8'hFF && !timer_flag_reg[0]
		&& !flagWriteOne[0] |=> !timer_flag_reg[0]; endproperty
	a_novf: assert property (p_novf) else $error("stray overflow");
	property p_irq; irqRequest == (timer_flag_reg & timer_irq_mask_reg);
	endproperty
	a_irq: assert property (p_irq) else $error("irq masking");
	property p_clr; stopped && flagWriteOne[1] |=> !timer_flag_reg[1];
	endproperty
	a_clr: assert property (p_clr) else $error("flag clear");
	c_ovf: cover property (runUp && count_value == 8'hFF);
	c_wr: cover property (countWrite ##1 stopped);
	c_irq: cover property (irqRequest[0]);
endmodule
bind etc_core etc_core_asserts u_chk (.clock, .nrst, .clock_select_field,
	.async_clock_select, .waveform_mode_bits_a, .waveform_mode_bit2,
	.countWrite, .countWrData, .flagWriteOne, .count_value,
	.timer_flag_reg, .timer_irq_mask_reg, .irqRequest);

// [testbench/etc_core_tb.sv]
// bench: directed checks of the eight-bit timer compare core
`timescale 1ns/1ps
module etc_core_tb;
	logic clock, nrst, async_clock_select, osc_pin_one;
	logic waveform_mode_bit2, countWrite, compare_out_a, compare_out_b;
	logic [1:0] waveform_mode_bits_a, portValue, portDirOut, pinOut, pinOutEn;
	logic [2:0] clock_select_field, flagWriteOne, irqServiced, irqRequest;
	logic [2:0] irqMaskWrite, irqMaskData, timer_flag_reg, timer_irq_mask_reg;
	logic [7:0] countWrData, count_value, compare_value_a, compare_value_b;
	logic [7:0] compareBufA, compareBufB;
	etc_pkg::etc_chan_s chanA, chanB;
	int bad_count, cmp_count;
	// packed views so one byte compare serves flags and pins
	wire logic [7:0] flg = {5'h0, timer_flag_reg};
	wire logic [7:0] pins = {2'h0, compare_out_b, compare_out_a,
		pinOutEn, pinOut};

	etc_core DUT (.clock, .nrst, .clock_select_field, .async_clock_select,
		.osc_pin_one, .waveform_mode_bits_a, .waveform_mode_bit2,
		.countWrite, .countWrData, .chanA, .chanB, .flagWriteOne,
		.irqServiced, .irqMaskWrite, .irqMaskData, .portValue, .portDirOut,
		.count_value, .compare_value_a, .compare_value_b, .compareBufA,
		.compareBufB, .timer_flag_reg, .timer_irq_mask_reg, .irqRequest,
		.compare_out_a, .compare_out_b, .pinOut, .pinOutEn);
////////////////////////////////////////////////////////////////////////////
	// 20 MHz clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// inputs move only at falling edges
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic chk(input string nm, input logic [7:0] e, g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrCnt(input logic [7:0] d);
		countWrite = 1'b1;
		countWrData = d;
		cyc(1);
		countWrite = 1'b0;
	endtask
	task automatic frcA(input logic [1:0] a);
		chanA.outputAction = a;
		chanA.forceStrobe = 1'b1;
		cyc(1);
		chanA.forceStrobe = 1'b0;
		// idle cycle so a following strobe is a fresh pulse
		cyc(1);
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
////////////////////////////////////////////////////////////////////////////
	// watchdog: tests need well under 100 cycles
	initial begin
		repeat (400) @(posedge clock);
		bad_count++;
		close_out();
	end
	// main sequence
	initial begin
		{nrst, clock_select_field, async_clock_select, osc_pin_one} = '0;
		{waveform_mode_bits_a, waveform_mode_bit2, countWrite} = '0;
		{countWrData, flagWriteOne, irqServiced, irqMaskWrite} = '0;
		{irqMaskData, portValue, portDirOut} = '0;
		chanA = '0;
		chanB = '0;
		cyc(5);
		nrst = 1'b1;
		cyc(3);
		chk("cnt", 8'h00, count_value);
		chk("flg", 8'h00, flg);
		chk("cmpA", 8'h00, compare_value_a);
		wrCnt(8'hFD);
		chk("cnt", 8'hFD, count_value);
		clock_select_field = 3'h1;
		cyc(3);
		chk("cnt", 8'h00, count_value);
		chk("flg", 8'h01, flg);
		chk("irq", 8'h00, {5'h0, irqRequest});
		irqMaskData = 3'h1;
		irqMaskWrite = 3'h1;
		cyc(1);
		irqMaskWrite = 3'h0;
		chk("mask", 8'h01, {5'h0, timer_irq_mask_reg});
		chk("irq", 8'h01, {5'h0, irqRequest});
		irqServiced = 3'h1;
		cyc(1);
		irqServiced = 3'h0;
		// wrap through zero matched both compares, count now at 02
		chk("flg", 8'h06, flg);
		flagWriteOne = 3'h6;
		wrCnt(8'h40);
		flagWriteOne = 3'h0;
		chk("flg", 8'h00, flg);
		chk("cnt", 8'h40, count_value);
		clock_select_field = 3'h0;
		chanA = '{2'b01, 1'b0, 1'b1, 8'h20};
		cyc(1);
		chanA.wrStrobe = 1'b0;
		chk("cmpA", 8'h20, compare_value_a);
		// output state set up before the pin turns output
		frcA(2'b10);
		chanA.outputAction = 2'b01;
		portDirOut = 2'b01;
		wrCnt(8'h1E);
		clock_select_field = 3'h1;
		cyc(3);
		chk("flg", 8'h02, flg);
		chk("pins", 8'h15, pins);
		clock_select_field = 3'h0;
		flagWriteOne = 3'h2;
		cyc(1);
		flagWriteOne = 3'h0;
		chk("flg", 8'h00, flg);
		wrCnt(8'h20);
		clock_select_field = 3'h1;
		cyc(2);
		chk("flg", 8'h00, flg);
		chk("cnt", 8'h22, count_value);
		clock_select_field = 3'h0;
		frcA(2'b10);
		chk("pins", 8'h04, pins);
		chk("flg", 8'h00, flg);
		chk("cnt", 8'h22, count_value);
		portValue = 2'b11;
		frcA(2'b00);
		chk("pins", 8'h07, pins);
		frcA(2'b11);
		chk("pins", 8'h17, pins);
		waveform_mode_bits_a = 2'b11;
		cyc(1);
		chk("pins", 8'h17, pins);
		chanB = '{2'b00, 1'b0, 1'b1, 8'h55};
		cyc(1);
		chanB.wrStrobe = 1'b0;
		chk("bufB", 8'h55, compareBufB);
		chk("bufA", 8'h00, compareBufA);
		chk("cmpB", 8'h00, compare_value_b);
		wrCnt(8'hFE);
		clock_select_field = 3'h1;
		cyc(4);
		chk("cmpB", 8'h55, compare_value_b);
		chk("cmpA", 8'h00, compare_value_a);
		clock_select_field = 3'h0;
		waveform_mode_bits_a = 2'b10;
		// ctc ceiling: the write went straight to active compare A, count clears there
		chanA.wrStrobe = 1'b1;
		wrCnt(8'h1F);
		chanA.wrStrobe = 1'b0;
		clock_select_field = 3'h1;
		cyc(2);
		chk("cnt", 8'h00, count_value);
		clock_select_field = 3'h0;
		waveform_mode_bits_a = 2'b00;
		async_clock_select = 1'b1;
		wrCnt(8'h00);
		clock_select_field = 3'h1;
		cyc(4);
		chk("cnt", 8'h00, count_value);
		osc_pin_one = 1'b1;
		cyc(6);
		chk("cnt", 8'h01, count_value);
		close_out();
	end
endmodule
